// ===== rtl/eif_regs.svh
// register offsets, field positions and reset values of the external interrupt front end
// Operation
// - falling edge on interrupt-1 line sets the interrupt-1 edge flag.
// - falling edge on interrupt-0 line sets the interrupt-0 edge flag.
// - core service acknowledge clears the matching request flag by hardware, except level-mode flags of interrupts 0 and 1.
// - interrupt-1 type bit: 1 means falling edge, 0 means low level.
// - interrupt-0 type bit: 1 means falling edge, 0 means low level.
// - interrupt-3 polarity bit: 0 falling edge active, 1 rising edge active.
// - interrupt-2 polarity bit selects falling (0) or rising (1) active edge.
// - request flags of interrupts 2 to 6 sit at bits 1 to 5.
// - timer overflow flags at bits 7 and 5; run bits 6 and 4 drive timer_one_run and timer_zero_run.
// - shared lines OR masked sources; each source has mask and flag bits.
// - user pins drive interrupt 0 (high priority) and 1 (low priority).
// - interrupts 2 and 3 come from own pins with selectable edge.
// - line 4 card, line 5 usb/clock/keypad, line 6 bus/supply/comparator.
// - combined sources of lines 4 to 6 become rising edges.
// - an external request reaches the core only while its enable bit is set; timer requests are not gated.
// - reading a shared source flag register clears its flags.
`ifndef EIF_REGS_SVH
`define EIF_REGS_SVH

`define EIF_TPC_ADDR     8'h88
`define EIF_IRF_ADDR     8'hC0
`define EIF_EPC_ADDR     8'hC8
`define EIF_IEN_ADDR     8'hD8
`define EIF_UMASK_ADDR   8'hD9
`define EIF_UHI_ADDR     8'hDA
`define EIF_F4_ADDR      8'hE0
`define EIF_M4_ADDR      8'hE1
`define EIF_F5_ADDR      8'hE2
`define EIF_M5_ADDR      8'hE3
`define EIF_F6_ADDR      8'hE4
`define EIF_M6_ADDR      8'hE5

`define EIF_RST_8        8'h00

`define EIF_TPC_T1_OVF   7
`define EIF_TPC_T1_RUN   6
`define EIF_TPC_T0_OVF   5
`define EIF_TPC_T0_RUN   4
`define EIF_TPC_E1_FLAG  3
`define EIF_TPC_E1_TYPE  2
`define EIF_TPC_E0_FLAG  1
`define EIF_TPC_E0_TYPE  0

`define EIF_EPC_E3_POL   6
`define EIF_EPC_E2_POL   5
`define EIF_EPC_MASK     8'h60

`define EIF_IRF_LO       1
`define EIF_IRF_HI       5
`define EIF_IRF_MASK     8'h3E

`define EIF_IEN_MASK     8'h7F

`endif

// ===== rtl/eif_pkg.sv
// types shared by the external interrupt front end
package eif_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } eif_bus_t;

  typedef struct packed {
    logic [6:0] ext;
    logic       timer_one;
    logic       timer_zero;
  } eif_ack_t;

  typedef struct packed {
    logic [6:0] ext;
    logic       timer_one;
    logic       timer_zero;
  } eif_req_t;

  typedef struct packed {
    logic       prev;
  } eif_edge_state_t;

  typedef struct packed {
    logic [7:0] tpc;
    logic [7:0] epc;
    logic [7:0] irf;
    logic [7:0] ien;
    logic [7:0] umask;
    logic [7:0] uhi;
    logic [7:0] f4;
    logic [7:0] m4;
    logic [7:0] f5;
    logic [7:0] m5;
    logic [7:0] f6;
    logic [7:0] m6;
    logic [7:0] rdata;
  } eif_state_t;

endpackage

// ===== rtl/eif_edge.sv
// one line sampler with selectable active edge
`timescale 1ns/1ps
module eif_edge
  import eif_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // line
  input  wire logic sig,
  input  wire logic rise_sel,
  // result
  output logic      lvl,
  output logic      pulse
);

  eif_edge_state_t st;
  eif_edge_state_t next_st;

  always_comb
  begin
    next_st      = st;
    next_st.prev = sig;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      st <= '{prev: 1'b1};
    else
      st <= next_st;
  end

  assign lvl   = st.prev;
  // reset holds prev high so a line low at release counts as a falling edge
  assign pulse = rise_sel ? (sig & ~st.prev) : (~sig & st.prev);

endmodule // eif_edge

// ===== rtl/eif_top.sv
// external interrupt front end: flags, edge detection and register port
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "eif_regs.svh"
module eif_top
  import eif_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // register port
  input  wire eif_bus_t   bus,
  output logic [7:0]      rd_data,
  // interrupt pins
  input  wire logic [7:0] user_io_pins,
  input  wire logic       ext_two_pin,
  input  wire logic       ext_three_pin,
  // peripheral source events
  input  wire logic [7:0] card_evt,
  input  wire logic [7:0] hub_evt,
  input  wire logic [7:0] sys_evt,
  input  wire logic       timer_zero_ovf,
  input  wire logic       timer_one_ovf,
  // core side
  input  wire eif_ack_t   ack,
  output eif_req_t        req,
  output logic            timer_zero_run,
  output logic            timer_one_run
);

  eif_state_t st;
  eif_state_t next_st;

  logic [6:0] line;
  logic [6:0] rise_sel;
  logic [6:0] lvl;
  logic [6:0] pulse;
  logic       hi_low;
  logic       lo_low;

  // user pins are active low; a masked low pin pulls its group line low
  assign hi_low = |(~user_io_pins & st.umask & st.uhi);
  assign lo_low = |(~user_io_pins & st.umask & ~st.uhi);

  assign line[0] = ~hi_low;
  assign line[1] = ~lo_low;
  assign line[2] = ext_two_pin;
  assign line[3] = ext_three_pin;
  // shared lines: masked source flags ORed into one level
  assign line[4] = |(st.f4 & st.m4);
  assign line[5] = |(st.f5 & st.m5);
  assign line[6] = |(st.f6 & st.m6);

  assign rise_sel[0] = 1'b0;
  assign rise_sel[1] = 1'b0;
  assign rise_sel[2] = st.epc[`EIF_EPC_E2_POL];
  assign rise_sel[3] = st.epc[`EIF_EPC_E3_POL];
  // the core sees lines 4 to 6 as rising edge events
  assign rise_sel[4] = 1'b1;
  assign rise_sel[5] = 1'b1;
  assign rise_sel[6] = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_line
      eif_edge u_edge
      (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .sig      (line[gi]),
        .rise_sel (rise_sel[gi]),
        .lvl      (lvl[gi]),
        .pulse    (pulse[gi])
      );
    end
  endgenerate

  always_comb
  begin
    next_st       = st;
    next_st.rdata = 8'h00;

    // software writes
    if (bus.wr)
    begin
      if (bus.addr == `EIF_TPC_ADDR)
      begin
        next_st.tpc = bus.wdata;
      end
      else if (bus.addr == `EIF_IRF_ADDR)
      begin
        next_st.irf = bus.wdata & `EIF_IRF_MASK;
      end
      else if (bus.addr == `EIF_EPC_ADDR)
      begin
        next_st.epc = bus.wdata & `EIF_EPC_MASK;
      end
      else if (bus.addr == `EIF_IEN_ADDR)
      begin
        next_st.ien = bus.wdata & `EIF_IEN_MASK;
      end
      else if (bus.addr == `EIF_UMASK_ADDR)
      begin
        next_st.umask = bus.wdata;
      end
      else if (bus.addr == `EIF_UHI_ADDR)
      begin
        next_st.uhi = bus.wdata;
      end
      else if (bus.addr == `EIF_M4_ADDR)
      begin
        next_st.m4 = bus.wdata;
      end
      else if (bus.addr == `EIF_M5_ADDR)
      begin
        next_st.m5 = bus.wdata;
      end
      else if (bus.addr == `EIF_M6_ADDR)
      begin
        next_st.m6 = bus.wdata;
      end
    end

    // software reads; source flag registers clear as they are read
    if (bus.rd)
    begin
      if (bus.addr == `EIF_TPC_ADDR)
      begin
        next_st.rdata = st.tpc;
      end
      else if (bus.addr == `EIF_IRF_ADDR)
      begin
        next_st.rdata = st.irf;
      end
      else if (bus.addr == `EIF_EPC_ADDR)
      begin
        next_st.rdata = st.epc;
      end
      else if (bus.addr == `EIF_IEN_ADDR)
      begin
        next_st.rdata = st.ien;
      end
      else if (bus.addr == `EIF_UMASK_ADDR)
      begin
        next_st.rdata = st.umask;
      end
      else if (bus.addr == `EIF_UHI_ADDR)
      begin
        next_st.rdata = st.uhi;
      end
      else if (bus.addr == `EIF_F4_ADDR)
      begin
        next_st.rdata = st.f4;
        next_st.f4    = `EIF_RST_8;
      end
      else if (bus.addr == `EIF_M4_ADDR)
      begin
        next_st.rdata = st.m4;
      end
      else if (bus.addr == `EIF_F5_ADDR)
      begin
        next_st.rdata = st.f5;
        next_st.f5    = `EIF_RST_8;
      end
      else if (bus.addr == `EIF_M5_ADDR)
      begin
        next_st.rdata = st.m5;
      end
      else if (bus.addr == `EIF_F6_ADDR)
      begin
        next_st.rdata = st.f6;
        next_st.f6    = `EIF_RST_8;
      end
      else if (bus.addr == `EIF_M6_ADDR)
      begin
        next_st.rdata = st.m6;
      end
      else
      begin
        next_st.rdata = 8'h00;
      end
    end

    // per-source events set after the read clear, so an event in the read cycle survives
    next_st.f4 = next_st.f4 | card_evt;
    next_st.f5 = next_st.f5 | hub_evt;
    next_st.f6 = next_st.f6 | sys_evt;

    // core acknowledges clear flags; sets below win on a collision
    if (ack.ext[0])
    begin
      next_st.tpc[`EIF_TPC_E0_FLAG] = 1'b0;
    end
    if (ack.ext[1])
    begin
      next_st.tpc[`EIF_TPC_E1_FLAG] = 1'b0;
    end
    for (int k = 2; k < 7; k++)
    begin
      if (ack.ext[k])
      begin
        next_st.irf[k - 1] = 1'b0;
      end
    end
    if (ack.timer_zero)
    begin
      next_st.tpc[`EIF_TPC_T0_OVF] = 1'b0;
    end
    if (ack.timer_one)
    begin
      next_st.tpc[`EIF_TPC_T1_OVF] = 1'b0;
    end

    // timer overflow flags
    if (timer_zero_ovf)
    begin
      next_st.tpc[`EIF_TPC_T0_OVF] = 1'b1;
    end
    if (timer_one_ovf)
    begin
      next_st.tpc[`EIF_TPC_T1_OVF] = 1'b1;
    end

    // interrupt 0: edge or level
    if (st.tpc[`EIF_TPC_E0_TYPE])
    begin
      if (pulse[0])
      begin
        next_st.tpc[`EIF_TPC_E0_FLAG] = 1'b1;
      end
    end
    else
    begin
      // level mode follows the sampled line, so service cannot drop a held request
      next_st.tpc[`EIF_TPC_E0_FLAG] = ~lvl[0];
    end

    // interrupt 1: edge or level
    if (st.tpc[`EIF_TPC_E1_TYPE])
    begin
      if (pulse[1])
      begin
        next_st.tpc[`EIF_TPC_E1_FLAG] = 1'b1;
      end
    end
    else
    begin
      next_st.tpc[`EIF_TPC_E1_FLAG] = ~lvl[1];
    end

    // interrupts 2 to 6 land at bits 1 to 5
    for (int k = 2; k < 7; k++)
    begin
      if (pulse[k])
      begin
        next_st.irf[k - 1] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      st.tpc   <= `EIF_RST_8;
      st.epc   <= `EIF_RST_8;
      st.irf   <= `EIF_RST_8;
      st.ien   <= `EIF_RST_8;
      st.umask <= `EIF_RST_8;
      st.uhi   <= `EIF_RST_8;
      st.f4    <= `EIF_RST_8;
      st.m4    <= `EIF_RST_8;
      st.f5    <= `EIF_RST_8;
      st.m5    <= `EIF_RST_8;
      st.f6    <= `EIF_RST_8;
      st.m6    <= `EIF_RST_8;
      st.rdata <= `EIF_RST_8;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data = st.rdata;

  // only enabled flags are presented to the core; timers are gated by the core itself
  assign req.ext[0]     = st.tpc[`EIF_TPC_E0_FLAG] & st.ien[0];
  assign req.ext[1]     = st.tpc[`EIF_TPC_E1_FLAG] & st.ien[1];
  assign req.ext[6:2]   = st.irf[`EIF_IRF_HI:`EIF_IRF_LO] & st.ien[6:2];
  assign req.timer_zero = st.tpc[`EIF_TPC_T0_OVF];
  assign req.timer_one  = st.tpc[`EIF_TPC_T1_OVF];

  // run bits are plain storage for the timers
  assign timer_zero_run = st.tpc[`EIF_TPC_T0_RUN];
  assign timer_one_run  = st.tpc[`EIF_TPC_T1_RUN];

endmodule // eif_top

// ===== bench/eif_top_props.sv
// port assertions of the external interrupt front end
`timescale 1ns/1ps
module eif_top_props
  import eif_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // watched ports
  input wire eif_bus_t   bus,
  input wire logic [7:0] rd_data,
  input wire logic       ext_two_pin,
  input wire logic [7:0] hub_evt,
  input wire logic       timer_zero_ovf,
  input wire logic       timer_one_ovf,
  input wire eif_ack_t   ack,
  input wire eif_req_t   req
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // read data only in the slot after a read strobe
  AST_RD_IDLE: assert property (!$past(bus.rd) |-> rd_data == 8'h00)
    else $error("read data outside slot");
  AST_T0_SET: assert property (timer_zero_ovf |=> req.timer_zero)
    else $error("timer 0 flag not set");
  AST_T1_SET: assert property (timer_one_ovf |=> req.timer_one)
    else $error("timer 1 flag not set");
  AST_T0_ACK: assert property (ack.timer_zero && !timer_zero_ovf && !bus.wr |=> !req.timer_zero)
    else $error("timer 0 flag kept after ack");
  AST_T1_ACK: assert property (ack.timer_one && !timer_one_ovf && !bus.wr |=> !req.timer_one)
    else $error("timer 1 flag kept after ack");
  // a stable pin makes no new set, so the ack must win
  AST_E2_ACK: assert property (ack.ext[2] && !bus.wr && ext_two_pin == $past(ext_two_pin) |=> !req.ext[2])
    else $error("line 2 kept after ack");
  AST_E2_SET: assert property ($rose(req.ext[2]) |->
    $past(bus.wr) || $past(ext_two_pin) != $past(ext_two_pin, 2))
    else $error("line 2 set without pin change");
  AST_L5_RISE: assert property ($rose(req.ext[5]) && !$past(bus.wr) && !$past(bus.wr, 2) |->
    $past(hub_evt, 2) != 8'h00)
    else $error("line 5 set without event");
endmodule // eif_top_props

bind eif_top eif_top_props i_props (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rd_data(rd_data),
  .ext_two_pin(ext_two_pin), .hub_evt(hub_evt), .timer_zero_ovf(timer_zero_ovf),
  .timer_one_ovf(timer_one_ovf), .ack(ack), .req(req));

// ===== bench/eif_core_model.sv
// behavioural core that services requests after a set latency
`timescale 1ns/1ps
module eif_core_model
  import eif_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // requests and service
  input  wire eif_req_t   req,
  input  wire logic [9:0] lat,
  output eif_ack_t        ack
);
  int cnt;
  // one ack for all pending lines keeps it small; a large lat holds service off
  always_ff @(posedge sys_clk)
  begin
    ack <= '0;
    if (!rst_b || ack != '0 || req == '0)
      cnt <= 0;
    else if (cnt >= int'(lat))
    begin
      ack <= eif_ack_t'(req);
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule // eif_core_model

// ===== bench/external_interrupt_front_end_bench.sv
// self-checking bench of the external interrupt front end
`timescale 1ns/1ps
`include "eif_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module external_interrupt_front_end_bench
  import eif_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst_b = 1'b0;
  eif_bus_t   bus = '0;
  logic [7:0] rd_data;
  logic [7:0] user_io_pins = 8'hFF;
  logic [7:0] card_evt = '0, hub_evt = '0, sys_evt = '0;
  // dedicated pins idle high; a low pin at reset release would read as a falling edge
  logic       ext_two_pin = 1'b1, ext_three_pin = 1'b1;
  logic       timer_zero_ovf = 1'b0, timer_one_ovf = 1'b0;
  logic       timer_zero_run, timer_one_run;
  logic [9:0] lat = 10'h3FF;
  eif_ack_t   ack;
  eif_req_t   req;
  int         n_fail = 0, compares = 0, cyc = 0;

  eif_top i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rd_data(rd_data), .user_io_pins(user_io_pins),
    .ext_two_pin(ext_two_pin), .ext_three_pin(ext_three_pin), .card_evt(card_evt), .hub_evt(hub_evt),
    .sys_evt(sys_evt), .timer_zero_ovf(timer_zero_ovf), .timer_one_ovf(timer_one_ovf), .ack(ack),
    .req(req), .timer_zero_run(timer_zero_run), .timer_one_run(timer_one_run));
  eif_core_model i_core (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .lat(lat), .ack(ack));

  always #2.5 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // the whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 `CHK(rd_data, e)
  endtask

  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge sys_clk);
    case (k)
      0: card_evt <= v;
      1: hub_evt <= v;
      default: sys_evt <= v;
    endcase
    @(posedge sys_clk);
    card_evt <= '0;
    hub_evt <= '0;
    sys_evt <= '0;
    tick(2);
  endtask

  task automatic t_reset();
    logic [7:0] adr [13] = '{8'h88, 8'hC0, 8'hC8, 8'hD8, 8'hD9, 8'hDA, 8'hE0, 8'hE1, 8'hE2, 8'hE3,
      8'hE4, 8'hE5, 8'h90};
    foreach (adr[i]) rd(adr[i], 8'h00);
    `CHK(req, 9'h000)
    wr(`EIF_IRF_ADDR, 8'hFF);
    rd(`EIF_IRF_ADDR, 8'h3E);
    wr(`EIF_IRF_ADDR, 8'h00);
  endtask

  // pin 0 feeds line 0, pin 1 feeds line 1
  task automatic t_user();
    wr(`EIF_UMASK_ADDR, 8'h03);
    wr(`EIF_UHI_ADDR, 8'h01);
    wr(`EIF_IEN_ADDR, 8'h03);
    @(posedge sys_clk) user_io_pins <= 8'hFC;
    tick(3);
    `CHK(req.ext[1:0], 2'b11)
    @(posedge sys_clk) user_io_pins <= 8'hFF;
    tick(3);
    `CHK(req.ext[1:0], 2'b00)
    wr(`EIF_TPC_ADDR, 8'h05);
    @(posedge sys_clk) user_io_pins <= 8'hFD;
    tick(3);
    `CHK(req.ext[1:0], 2'b10)
    @(posedge sys_clk) user_io_pins <= 8'hFF;
    tick(2);
    rd(`EIF_TPC_ADDR, 8'h0D);
    @(posedge sys_clk) user_io_pins <= 8'hFE;
    @(posedge sys_clk) user_io_pins <= 8'hFF;
    tick(2);
    rd(`EIF_TPC_ADDR, 8'h0F);
    @(posedge sys_clk) lat <= 10'h002;
    tick(8);
    `CHK(req.ext[1:0], 2'b00)
    rd(`EIF_TPC_ADDR, 8'h05);
    @(posedge sys_clk) lat <= 10'h3FF;
  endtask

  task automatic t_pol();
    logic [7:0] pol [3] = '{8'h00, 8'h60, 8'h40};
    logic [7:0] exp [3] = '{8'h06, 8'h06, 8'h02};
    wr(`EIF_IEN_ADDR, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(`EIF_EPC_ADDR, pol[i]);
      wr(`EIF_IRF_ADDR, 8'h00);
      @(posedge sys_clk);
      ext_two_pin <= ~ext_two_pin;
      ext_three_pin <= ~ext_three_pin;
      tick(2);
      rd(`EIF_IRF_ADDR, exp[i]);
      `CHK(req.ext[3:2], 2'b00)
    end
    wr(`EIF_IEN_ADDR, 8'h0C);
    tick(1);
    `CHK(req.ext[3:2], 2'b01)
    wr(`EIF_EPC_ADDR, 8'hFF);
    rd(`EIF_EPC_ADDR, 8'h60);
    wr(`EIF_EPC_ADDR, 8'h00);
    @(posedge sys_clk) lat <= 10'h002;
    tick(8);
    rd(`EIF_IRF_ADDR, 8'h00);
    @(posedge sys_clk) lat <= 10'h3FF;
  endtask

  // line 4 card, line 5 hub, line 6 system sources; only bit 1 unmasked
  task automatic t_shared();
    wr(`EIF_IEN_ADDR, 8'h70);
    for (int k = 0; k < 3; k++)
    begin
      wr(8'hE1 + 8'(2 * k), 8'h02);
      pulse(k, 8'h01);
      rd(`EIF_IRF_ADDR, 8'h00);
      rd(8'hE0 + 8'(2 * k), 8'h01);
      pulse(k, 8'h02);
      rd(`EIF_IRF_ADDR, 8'h08 << k);
      rd(8'hE0 + 8'(2 * k), 8'h02);
      rd(8'hE0 + 8'(2 * k), 8'h00);
      wr(`EIF_IRF_ADDR, 8'h00);
    end
  endtask

  task automatic t_timer();
    @(posedge sys_clk) timer_zero_ovf <= 1'b1;
    @(posedge sys_clk);
    timer_zero_ovf <= 1'b0;
    timer_one_ovf <= 1'b1;
    @(posedge sys_clk) timer_one_ovf <= 1'b0;
    tick(2);
    `CHK({req.timer_one, req.timer_zero}, 2'b11)
    rd(`EIF_TPC_ADDR, 8'hA5);
    wr(`EIF_TPC_ADDR, 8'hF5);
    `CHK({timer_one_run, timer_zero_run, req.ext}, 9'h180)
    @(posedge sys_clk) lat <= 10'h002;
    tick(8);
    `CHK({req.timer_one, req.timer_zero}, 2'b00)
    rd(`EIF_TPC_ADDR, 8'h55);
  endtask

  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_user();
    t_pol();
    t_shared();
    t_timer();
    report_and_stop();
  end
endmodule // external_interrupt_front_end_bench
